// ==== hdl/pgm_defines.svh ====
// Register map, field positions, reset values and timing counts of the
// power-good and warning monitor.
// Assumes a 100 MHz core clock and an 8-bit register port.
`ifndef PGM_DEFINES_SVH
`define PGM_DEFINES_SVH

// Register offsets on the 8-bit register port.
`define PGM_ADDR_CTRL1   8'h00
`define PGM_ADDR_CTRL2   8'h01
`define PGM_ADDR_FAULT   8'h02
`define PGM_ADDR_INT     8'h03
`define PGM_ADDR_MASK    8'h04
`define PGM_ADDR_STATUS  8'h05
`define PGM_ADDR_ILIM    8'h06
`define PGM_ADDR_CONFIG  8'h07

// Control 1 fields: two rail selects, two window selects, pin options.
`define PGM_C1_RAILSEL   0
`define PGM_C1_WINDOW    2
`define PGM_C1_POL       4
`define PGM_C1_OD        5
// Control 2 fields.
`define PGM_C2_TWSEL     0
`define PGM_C2_MODE      1
`define PGM_C2_FHOLD     2
// Interrupt flag fields (two peak flags from bit 0).
`define PGM_INT_PEAK     0
`define PGM_INT_TW       2
`define PGM_INT_OV       3
`define PGM_INT_TRIP     4
// Mask fields.
`define PGM_MSK_PEAK     0
`define PGM_MSK_TW       2
// Status fields.
`define PGM_ST_PEAK      0
`define PGM_ST_TW        2
`define PGM_ST_PG        3
`define PGM_ST_OV        4
`define PGM_ST_TRIP      5
// Peak current setting fields, three bits each.
`define PGM_ILIM_R0      0
`define PGM_ILIM_R1      4
// Config fields.
`define PGM_CFG_TWLVL    0

// Reset values.
`define PGM_RST_CTRL1    8'h13
`define PGM_RST_CTRL2    8'h00
`define PGM_RST_MASK     8'h00
`define PGM_RST_ILIM     8'h00
`define PGM_RST_CONFIG   8'h00

// Timing: figures in microseconds and the clock rate in MHz.
`define PGM_CLK_MHZ      100
`define PGM_GATE_US      800
`define PGM_QUAL_US      20
`define PGM_DEB_US       6
`define PGM_GATE_CYCLES  (`PGM_GATE_US * `PGM_CLK_MHZ)
`define PGM_QUAL_CYCLES  (`PGM_QUAL_US * `PGM_CLK_MHZ)
`define PGM_DEB_CYCLES   (`PGM_DEB_US * `PGM_CLK_MHZ)

`endif

// ==== hdl/pgm_pkg.sv ====
// Types shared by the power-good monitor modules.
// Assumes nothing beyond a SystemVerilog compiler.
package pgm_pkg;

  // Sequencing of the power-good output after configuration load.
  typedef enum logic [1:0] {
    PGM_LOAD,
    PGM_WAIT_EN,
    PGM_RUN
  } pgm_state_t;

endpackage : pgm_pkg

// ==== hdl/pgm_flt_if.sv ====
// Carrier between the monitor and its debounce filter.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps

interface pgm_flt_if;
  logic sample;    // Raw level to be filtered.
  logic filtered;  // Debounced level.

  // The monitor drives the raw level and reads the result.
  modport owner (output sample, input filtered);
  // The filter reads the raw level and drives the result.
  modport filt (input sample, output filtered);
endinterface : pgm_flt_if

// ==== hdl/pgm_debounce.sv ====
// Symmetric debounce filter for the power-good level.
// Assumes a synchronous input and the 100 MHz core clock.
`timescale 1ns/10ps
`include "pgm_defines.svh"

module pgm_debounce
  import pgm_pkg::*;
(
  input  wire logic clk,
  input  wire logic srst,
  pgm_flt_if.filt   flt
);

  localparam logic [9:0] DEB_LAST = 10'(`PGM_DEB_CYCLES - 1);

  logic [9:0] cnt_reg;      // Cycles the input has differed.
  logic [9:0] cnt_next;     // Next count.
  logic       level_reg;    // Filtered level.
  logic       level_next;   // Next filtered level.

  // The count restarts whenever the input agrees again, so a glitch
  // shorter than the window never reaches the output.
  always_comb begin
    cnt_next   = 10'h000;
    level_next = level_reg;
    if (flt.sample != level_reg) begin
      if (cnt_reg == DEB_LAST) begin
        level_next = flt.sample;
      end else begin
        cnt_next = cnt_reg + 10'h001;
      end
    end
  end

  // Registers only; the reset level is inactive.
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_reg   <= 10'h000;
      level_reg <= 1'b0;
    end else begin
      cnt_reg   <= cnt_next;
      level_reg <= level_next;
    end
  end

  assign flt.filtered = level_reg;

endmodule // pgm_debounce

// ==== hdl/pgm_monitor.sv ====
// Power-good combiner, rail fault latch and warning interrupts.
// Assumes synchronous inputs, a 100 MHz clock and srst as the supply
// undervoltage reset.
//
// Operation
// - Per-rail select bits choose voltage monitors.
// - Disabled rails never pull power-good inactive.
// - Optional thermal warning source for power-good.
// - Power-good needs every selected source valid.
// - Window bit: undervoltage only, or both.
// - Pin polarity and push-pull/open-drain bits.
// - Mode bit from OTP: gated or continuous.
// - Gated mode asserts after configuration load.
// - Gated mode holds power-good 800 us.
// - Gated faults latch, stop monitoring until cleared.
// - Faults and interrupt flags are write-one-to-clear.
// - Undervoltage reset clears pending flags.
// - Continuous: assert, drop on enable, then track.
// - Continuous power-good follows monitors unlatched.
// - Continuous rail faults latch until cleared.
// - Continuous mode: inactive during voltage change.
// - Fault-hold option keeps power-good inactive.
// - Three-bit peak current setting per rail.
// - 20 us peak regulation sets flag, interrupt.
// - Peak status, clearable flag, mask per rail.
// - Threshold select bit for thermal warning.
// - Thermal warning flag, status, clear, mask.
// - Interrupt low while unmasked flag pending.
// - Power-good debounced 6 us both edges.
// - Polarity inverts only the physical pin.
`timescale 1ns/10ps
`include "pgm_defines.svh"

module pgm_monitor
  import pgm_pkg::*;
#(
  parameter int unsigned GATE_CYCLES = `PGM_GATE_CYCLES
)
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrEn,
  input  wire logic       regRdEn,
  output logic      [7:0] regRdData,
  input  wire logic       cfgLoadDone,
  input  wire logic       otpBehaviourDefault,
  input  wire logic [1:0] railEnable,
  input  wire logic [1:0] railUnderOk,
  input  wire logic [1:0] railOverOk,
  input  wire logic [1:0] railRamping,
  input  wire logic [1:0] peakLimitActive,
  input  wire logic       tempWarnRaw,
  input  wire logic       inputOvRaw,
  input  wire logic       thermalTripRaw,
  output logic      [2:0] peakCurrentSetting0,
  output logic      [2:0] peakCurrentSetting1,
  output logic            tempWarnThresholdSelect,
  output logic            powerGoodOut,
  output logic            powerGoodOutEnN,
  output logic            irqOutN
);

  localparam logic [16:0] GATE_LOAD = 17'(GATE_CYCLES - 1);
  localparam logic [10:0] QUAL_LAST = 11'(`PGM_QUAL_CYCLES);

  // Software-visible registers.
  logic [7:0] ctrl1_reg;        // Rail selects, windows, pin options.
  logic [7:0] ctrl1_next;
  logic [7:0] ctrl2_reg;        // Warning select, mode, fault hold.
  logic [7:0] ctrl2_next;
  logic [1:0] fault_reg;        // Rail fault latch.
  logic [1:0] fault_next;
  logic [4:0] intFlag_reg;      // Interrupt flags.
  logic [4:0] intFlag_next;
  logic [7:0] mask_reg;         // Interrupt masks.
  logic [7:0] mask_next;
  logic [7:0] ilim_reg;         // Peak current settings.
  logic [7:0] ilim_next;
  logic [7:0] config_reg;       // Warning threshold select.
  logic [7:0] config_next;
  logic [7:0] rdData_reg;       // Read data, valid one cycle later.
  logic [7:0] rdData_next;

  // Sequencing state.
  pgm_state_t  state_reg;       // Power-good sequencing state.
  pgm_state_t  state_next;
  logic [16:0] gateCnt_reg;     // Gated hold-off countdown.
  logic [16:0] gateCnt_next;
  logic        pgTarget_reg;    // Unfiltered power-good level.
  logic        pgTarget_next;
  logic [1:0]  enPrev_reg;      // Previous rail enables.
  logic [1:0]  rampPrev_reg;    // Previous ramp indications.

  // Pin stage.
  logic        pgPin_reg;       // Pin level.
  logic        pgPin_next;
  logic        pgOenN_reg;      // Pin output enable, low drives.
  logic        pgOenN_next;
  logic        irqN_reg;        // Interrupt pin level.
  logic        irqN_next;

  // Combinational helpers.
  logic [1:0]  railMonitored;   // Selected and enabled rails.
  logic [1:0]  railOk;          // Monitor result per rail.
  logic [1:0]  railValid;       // Rail does not block power-good.
  logic [1:0]  peakStat;        // Qualified peak regulation.
  logic        pgValid;         // All selected sources valid.
  logic        event_start;     // Enable or voltage-change start.
  logic        gatedMode;       // Behaviour select: high when gated.
  logic        wrHit;           // Write strobe helper.
  logic        pgFiltered;      // Debounced power-good.

  pgm_flt_if pgFlt ();

  // The debounce filter sits between the combiner and both the pin
  // and the status bit so that the two never disagree.
  pgm_debounce u_debounce (
    .clk  (clk),
    .srst (srst),
    .flt  (pgFlt)
  );

  assign pgFlt.sample = pgTarget_reg;
  assign pgFiltered   = pgFlt.filtered;
  assign gatedMode    = ~ctrl2_reg[`PGM_C2_MODE];
  assign wrHit        = regWrEn;

  // Per-rail monitoring and peak-current qualification.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_rail
      logic [10:0] qualCnt_reg;   // Cycles spent in peak regulation.
      logic [10:0] qualCnt_next;

      // Only enabled, selected rails have their voltage monitors checked.
      assign railMonitored[gi] = ctrl1_reg[`PGM_C1_RAILSEL + gi] &
                                 railEnable[gi];
      // Window bit low ignores the overvoltage comparator.
      assign railOk[gi] = railUnderOk[gi] &
                          (~ctrl1_reg[`PGM_C1_WINDOW + gi] |
                           railOverOk[gi]);
      assign railValid[gi] = ~railMonitored[gi] | railOk[gi];

      // The count restarts on any break in regulation; it saturates
      // so that status stays high while regulation lasts.
      always_comb begin
        qualCnt_next = 11'h000;
        if (peakLimitActive[gi]) begin
          if (qualCnt_reg == QUAL_LAST) begin
            qualCnt_next = qualCnt_reg;
          end else begin
            qualCnt_next = qualCnt_reg + 11'h001;
          end
        end
      end

      // Counter register.
      always_ff @(posedge clk) begin
        if (srst) begin
          qualCnt_reg <= 11'h000;
        end else begin
          qualCnt_reg <= qualCnt_next;
        end
      end

      assign peakStat[gi] = (qualCnt_reg == QUAL_LAST);
    end
  endgenerate

  // The combination of every selected source. Pending input
  // overvoltage and thermal trip flags block it, not the raw levels.
  assign pgValid = (&railValid) &
                   ~(ctrl2_reg[`PGM_C2_TWSEL] & tempWarnRaw) &
                   ~intFlag_reg[`PGM_INT_OV] &
                   ~intFlag_reg[`PGM_INT_TRIP];

  assign event_start = |(railEnable & ~enPrev_reg) |
                       |(railRamping & ~rampPrev_reg);

  // Register file: writes, write-one-to-clear and flag setting.
  always_comb begin
    logic [1:0] faultSet;
    logic [4:0] flagSet;
    logic       checkOn;
    faultSet    = 2'h0;
    flagSet     = 5'h00;
    checkOn     = 1'b0;
    ctrl1_next  = ctrl1_reg;
    ctrl2_next  = ctrl2_reg;
    mask_next   = mask_reg;
    ilim_next   = ilim_reg;
    config_next = config_reg;
    fault_next  = fault_reg;
    intFlag_next = intFlag_reg;

    // Load the behaviour default while leaving configuration load.
    if (state_reg == PGM_LOAD && cfgLoadDone) begin
      ctrl2_next[`PGM_C2_MODE] = otpBehaviourDefault;
    end

    if (wrHit) begin
      case (regAddr)
        `PGM_ADDR_CTRL1:  ctrl1_next = regWrData;
        `PGM_ADDR_CTRL2:  ctrl2_next = regWrData;
        `PGM_ADDR_MASK:   mask_next = regWrData;
        `PGM_ADDR_ILIM:   ilim_next = regWrData;
        `PGM_ADDR_CONFIG: config_next = regWrData;
        `PGM_ADDR_FAULT: begin
          fault_next = fault_reg & ~regWrData[1:0];
        end
        `PGM_ADDR_INT: begin
          intFlag_next = intFlag_reg & ~regWrData[4:0];
        end
        default: begin
          // Writes elsewhere are dropped.
        end
      endcase
    end

    // Rail faults are checked after the hold-off in gated mode and
    // outside voltage changes in continuous mode.
    for (int i = 0; i < 2; i++) begin
      if (gatedMode) begin
        checkOn = (state_reg == PGM_RUN) && !event_start && ~|gateCnt_reg;
      end else begin
        checkOn = (state_reg == PGM_RUN) && !railRamping[i];
      end
      faultSet[i] = checkOn & railMonitored[i] & ~railOk[i];
    end

    flagSet[`PGM_INT_PEAK + 0] = peakStat[0];
    flagSet[`PGM_INT_PEAK + 1] = peakStat[1];
    flagSet[`PGM_INT_TW]       = tempWarnRaw;
    flagSet[`PGM_INT_OV]       = inputOvRaw;
    flagSet[`PGM_INT_TRIP]     = thermalTripRaw;

    // A set in the clearing cycle, or a persisting cause, wins.
    fault_next   = fault_next | faultSet;
    intFlag_next = intFlag_next | flagSet;
  end

  // Register file storage; srst models the undervoltage reset.
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl1_reg   <= `PGM_RST_CTRL1;
      ctrl2_reg   <= `PGM_RST_CTRL2;
      mask_reg    <= `PGM_RST_MASK;
      ilim_reg    <= `PGM_RST_ILIM;
      config_reg  <= `PGM_RST_CONFIG;
      fault_reg   <= 2'h0;
      intFlag_reg <= 5'h00;
    end else begin
      ctrl1_reg   <= ctrl1_next;
      ctrl2_reg   <= ctrl2_next;
      mask_reg    <= mask_next;
      ilim_reg    <= ilim_next;
      config_reg  <= config_next;
      fault_reg   <= fault_next;
      intFlag_reg <= intFlag_next;
    end
  end

  // Power-good sequencing. In gated mode the level is frozen while
  // the hold-off runs, which lets a wired-OR with the enable pin act
  // as a reset generator without chattering during start-up.
  always_comb begin
    state_next    = state_reg;
    gateCnt_next  = gateCnt_reg;
    pgTarget_next = pgTarget_reg;

    // Each new enable or voltage change restarts the hold-off.
    if (event_start) begin
      gateCnt_next = GATE_LOAD;
    end else if (gateCnt_reg != 17'h00000) begin
      gateCnt_next = gateCnt_reg - 17'h00001;
    end

    case (state_reg)
      PGM_LOAD: begin
        pgTarget_next = 1'b0;
        if (cfgLoadDone) begin
          pgTarget_next = 1'b1;
          if (otpBehaviourDefault) begin
            state_next = PGM_WAIT_EN;
          end else begin
            state_next = PGM_RUN;
          end
        end
      end
      PGM_WAIT_EN: begin
        // Continuous mode stays asserted until a rail is enabled.
        if (|railEnable) begin
          pgTarget_next = 1'b0;
          state_next    = PGM_RUN;
        end
      end
      PGM_RUN: begin
        if (gatedMode) begin
          // Frozen during hold-off; afterwards latched faults keep
          // it inactive until software clears them.
          if (!event_start && gateCnt_reg == 17'h00000) begin
            pgTarget_next = pgValid & ~(|fault_reg);
          end
        end else begin
          pgTarget_next = pgValid & ~(|(railRamping & railEnable)) &
                          ~(ctrl2_reg[`PGM_C2_FHOLD] &
                            (|fault_reg));
        end
      end
      default: begin
        state_next = PGM_LOAD;
      end
    endcase

    // The fault-hold option also applies in gated mode.
    if (state_reg == PGM_RUN && ctrl2_reg[`PGM_C2_FHOLD] &&
        |fault_reg) begin
      pgTarget_next = 1'b0;
    end
  end

  // Sequencing registers.
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg    <= PGM_LOAD;
      gateCnt_reg  <= 17'h00000;
      pgTarget_reg <= 1'b0;
      enPrev_reg   <= 2'h0;
      rampPrev_reg <= 2'h0;
    end else begin
      state_reg    <= state_next;
      gateCnt_reg  <= gateCnt_next;
      pgTarget_reg <= pgTarget_next;
      enPrev_reg   <= railEnable;
      rampPrev_reg <= railRamping;
    end
  end

  // Pin stage and read port. Polarity touches only the pin; the
  // status bit keeps native polarity. Open drain drives only low.
  always_comb begin
    pgPin_next = ctrl1_reg[`PGM_C1_POL] ? pgFiltered
                                         : ~pgFiltered;
    pgOenN_next = ctrl1_reg[`PGM_C1_OD] & pgPin_next;
    irqN_next = ~(|(intFlag_reg[1:0] & ~mask_reg[1:0]) |
                  (intFlag_reg[`PGM_INT_TW] &
                   ~mask_reg[`PGM_MSK_TW]) |
                  intFlag_reg[`PGM_INT_OV] |
                  intFlag_reg[`PGM_INT_TRIP]);
    rdData_next = 8'h00;
    if (regRdEn) begin
      case (regAddr)
        `PGM_ADDR_CTRL1:  rdData_next = ctrl1_reg;
        `PGM_ADDR_CTRL2:  rdData_next = ctrl2_reg;
        `PGM_ADDR_FAULT:  rdData_next = {6'h00, fault_reg};
        `PGM_ADDR_INT:    rdData_next = {3'h0, intFlag_reg};
        `PGM_ADDR_MASK:   rdData_next = mask_reg;
        `PGM_ADDR_ILIM:   rdData_next = ilim_reg;
        `PGM_ADDR_CONFIG: rdData_next = config_reg;
        `PGM_ADDR_STATUS: begin
          rdData_next = {2'h0, thermalTripRaw, inputOvRaw,
                         pgFiltered, tempWarnRaw, peakStat};
        end
        default: begin
          rdData_next = 8'h00;
        end
      endcase
    end
  end

  // Output registers; the pin is driven low during reset.
  always_ff @(posedge clk) begin
    if (srst) begin
      pgPin_reg  <= 1'b0;
      pgOenN_reg <= 1'b0;
      irqN_reg   <= 1'b1;
      rdData_reg <= 8'h00;
    end else begin
      pgPin_reg  <= pgPin_next;
      pgOenN_reg <= pgOenN_next;
      irqN_reg   <= irqN_next;
      rdData_reg <= rdData_next;
    end
  end

  // Every output comes straight from a register.
  assign regRdData               = rdData_reg;
  assign powerGoodOut            = pgPin_reg;
  assign powerGoodOutEnN         = pgOenN_reg;
  assign irqOutN                 = irqN_reg;
  assign peakCurrentSetting0     = ilim_reg[`PGM_ILIM_R0 +: 3];
  assign peakCurrentSetting1     = ilim_reg[`PGM_ILIM_R1 +: 3];
  assign tempWarnThresholdSelect = config_reg[`PGM_CFG_TWLVL];

endmodule // pgm_monitor

// ==== test/pgm_monitor_sva.sv ====
// Concurrent checks on the ports of the power-good monitor.
// Assumes one clock domain and srst as its synchronous reset.
`timescale 1ns/10ps
`include "pgm_defines.svh"

module pgm_monitor_sva (
  input wire logic       clk,
  input wire logic       srst,
  input wire logic [7:0] regAddr,
  input wire logic       regWrEn,
  input wire logic       regRdEn,
  input wire logic [7:0] regRdData,
  input wire logic [1:0] peakLimitActive,
  input wire logic       tempWarnRaw,
  input wire logic       inputOvRaw,
  input wire logic       thermalTripRaw,
  input wire logic [2:0] peakCurrentSetting0,
  input wire logic       tempWarnThresholdSelect,
  input wire logic       powerGoodOut,
  input wire logic       powerGoodOutEnN,
  input wire logic       irqOutN
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // Three cycles with no register write, so no pin option can move.
  sequence quietWr;
    !regWrEn [*3];
  endsequence

  a_rd_idle_zero: assert property (!$past(regRdEn) |-> regRdData == 8'h00)
    else $error("read data not zero outside the read answer cycle");
  a_od_released: assert property (powerGoodOutEnN |-> powerGoodOut)
    else $error("pin released while its level is low");
  a_ov_irq: assert property (inputOvRaw |-> ##2 !irqOutN)
    else $error("input overvoltage did not pull the interrupt low");
  a_trip_irq: assert property (thermalTripRaw |-> ##2 !irqOutN)
    else $error("thermal trip did not pull the interrupt low");
  a_irq_release: assert property ($rose(irqOutN) |-> $past(regWrEn, 2))
    else $error("interrupt released without a register write");
  // A falling interrupt needs a raw cause or an unmasking write.
  a_irq_cause: assert property ($fell(irqOutN) |-> $past(regWrEn, 2) ||
    $past(inputOvRaw | thermalTripRaw | tempWarnRaw, 2) ||
    $past(|peakLimitActive, 3))
    else $error("interrupt fell with no cause");
  a_pin_debounce: assert property (quietWr ##0 $changed(powerGoodOut)
    ##1 quietWr |=> $stable(powerGoodOut))
    else $error("power-good pin changed twice within the filter time");
  a_ilim_write: assert property ($changed(peakCurrentSetting0) |->
    $past(regWrEn) && $past(regAddr) == `PGM_ADDR_ILIM)
    else $error("peak current setting changed without a write");
  a_level_write: assert property ($changed(tempWarnThresholdSelect) |->
    $past(regWrEn) && $past(regAddr) == `PGM_ADDR_CONFIG)
    else $error("threshold select changed without a write");
endmodule // pgm_monitor_sva

bind pgm_monitor pgm_monitor_sva pgm_monitor_sva_i (
  .clk, .srst, .regAddr, .regWrEn, .regRdEn, .regRdData,
  .peakLimitActive, .tempWarnRaw, .inputOvRaw, .thermalTripRaw,
  .peakCurrentSetting0, .tempWarnThresholdSelect, .powerGoodOut,
  .powerGoodOutEnN, .irqOutN
);

// ==== test/pgm_host_model.sv ====
// Host side of the power-good and interrupt pins.
// Assumes a board pull-up on the power-good pin, as open-drain wiring needs.
`timescale 1ns/10ps

module pgm_host_model (
  input  wire logic pgLevel,
  input  wire logic pgEnN,
  input  wire logic irqN,
  output logic      pinSeen,
  output logic      irqSeen
);
  // A released pin floats up to the pull-up, never to its last value.
  assign pinSeen = pgEnN ? 1'b1 : pgLevel;
  // The host sees an interrupt while the line is low.
  assign irqSeen = !irqN;
endmodule // pgm_host_model

// ==== test/power_good_and_warning_monitor_test.sv ====
// Self-checking bench of the power-good monitor over its register port.
// Assumes a 100 MHz clock and a short gate count for simulation.
`timescale 1ns/10ps
`include "pgm_defines.svh"

module power_good_and_warning_monitor_test;
  import pgm_pkg::*;
  logic       clk, srst, regWrEn, regRdEn, cfgLoadDone, otpBit;
  logic [7:0] regAddr, regWrData, regRdData;
  logic [1:0] railEnable, railUnderOk, railOverOk, railRamping, peak;
  logic       tempWarnRaw, inputOvRaw, thermalTripRaw, tLevel;
  logic [2:0] ilim0, ilim1;
  logic       pgPin, pgEnN, irqN, pinSeen, irqSeen;
  int         errTotal, compares, cycles;

  pgm_monitor #(.GATE_CYCLES(50)) pgm_monitor_i (
    .clk(clk), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .cfgLoadDone(cfgLoadDone), .otpBehaviourDefault(otpBit),
    .railEnable(railEnable), .railUnderOk(railUnderOk),
    .railOverOk(railOverOk), .railRamping(railRamping),
    .peakLimitActive(peak), .tempWarnRaw(tempWarnRaw),
    .inputOvRaw(inputOvRaw), .thermalTripRaw(thermalTripRaw),
    .peakCurrentSetting0(ilim0), .peakCurrentSetting1(ilim1),
    .tempWarnThresholdSelect(tLevel), .powerGoodOut(pgPin),
    .powerGoodOutEnN(pgEnN), .irqOutN(irqN));
  pgm_host_model pgm_host_model_i (.pgLevel(pgPin), .pgEnN(pgEnN),
    .irqN(irqN), .pinSeen(pinSeen), .irqSeen(irqSeen));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input string n, input logic [7:0] e, g);
    compares++;
    if (g !== e) begin
      errTotal++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  // Strobes drop after one edge; an idle edge keeps calls apart.
  task automatic wr(input logic [7:0] a, d);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    cyc(1);
    regWrEn <= 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a, e, input string n);
    regAddr <= a;
    regRdEn <= 1'b1;
    cyc(1);
    regRdEn <= 1'b0;
    #1 chk(n, e, regRdData);
    cyc(1);
  endtask
  // Wait out the 600-cycle filter, then read the status.
  task automatic st(input logic [7:0] e);
    cyc(700);
    rd(`PGM_ADDR_STATUS, e, "status");
  endtask
  task automatic bit1(input string n, input logic e, g);
    chk(n, {7'h0, e}, {7'h0, g});
  endtask
  task automatic rst6;
    srst <= 1'b1;
    cfgLoadDone <= 1'b0;
    railEnable <= 2'b00;
    cyc(6);
    srst <= 1'b0;
    cyc(1);
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, errTotal);
    if (errTotal == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // A hang counts as a mismatch and closes the run.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      errTotal++;
      test_done();
    end
  end

  initial begin
    {srst, regWrEn, regRdEn, cfgLoadDone, otpBit} = 5'b10000;
    {regAddr, regWrData} = '0;
    {railEnable, railRamping, peak, railUnderOk, railOverOk} = 10'h00f;
    {tempWarnRaw, inputOvRaw, thermalTripRaw} = 3'b000;
    {errTotal, compares, cycles} = '0;
    rst6();
    rd(`PGM_ADDR_CTRL1, `PGM_RST_CTRL1, "ctrl1");
    rd(`PGM_ADDR_MASK, `PGM_RST_MASK, "mask");
    rd(8'h08, 8'h00, "unmapped");
    rd(`PGM_ADDR_STATUS, 8'h00, "status");
    wr(`PGM_ADDR_ILIM, 8'h75);
    chk("ilim", 8'h75, {1'b0, ilim1, 1'b0, ilim0});
    wr(`PGM_ADDR_CONFIG, 8'h01);
    bit1("level", 1'b1, tLevel);
    // Gated mode: power-good asserts after configuration load.
    cfgLoadDone <= 1'b1;
    railEnable <= 2'b11;
    st(8'h08);
    rd(`PGM_ADDR_CTRL2, 8'h00, "mode");
    bit1("pin", 1'b1, pinSeen);
    railEnable <= 2'b01;
    cyc(2);
    railEnable <= 2'b11;
    railUnderOk <= 2'b01;
    cyc(40);
    railUnderOk <= 2'b11;
    rd(`PGM_ADDR_FAULT, 8'h00, "gated fault");
    railUnderOk <= 2'b10;
    st(8'h00);
    rd(`PGM_ADDR_FAULT, 8'h01, "fault");
    railUnderOk <= 2'b11;
    st(8'h00);
    wr(`PGM_ADDR_FAULT, 8'h01);
    st(8'h08);
    railEnable <= 2'b10;
    railUnderOk <= 2'b10;
    st(8'h08);
    railUnderOk <= 2'b11;
    railEnable <= 2'b11;
    railOverOk <= 2'b10;
    st(8'h08);
    wr(`PGM_ADDR_CTRL1, 8'h17);
    st(8'h00);
    railOverOk <= 2'b11;
    wr(`PGM_ADDR_FAULT, 8'h01);
    wr(`PGM_ADDR_CTRL1, 8'h13);
    // Input overvoltage, then thermal trip.
    for (int i = 0; i < 2; i++) begin
      {thermalTripRaw, inputOvRaw} <= 2'b01 << i;
      cyc(3);
      bit1("irq", 1'b1, irqSeen);
      {thermalTripRaw, inputOvRaw} <= 2'b00;
      st(8'h00);
      wr(`PGM_ADDR_INT, 8'h08 << i);
      st(8'h08);
      bit1("irq", 1'b0, irqSeen);
    end
    wr(`PGM_ADDR_CTRL2, 8'h01);
    tempWarnRaw <= 1'b1;
    cyc(3);
    wr(`PGM_ADDR_INT, 8'h04);
    rd(`PGM_ADDR_INT, 8'h04, "warn flag");
    st(8'h04);
    tempWarnRaw <= 1'b0;
    wr(`PGM_ADDR_INT, 8'h04);
    wr(`PGM_ADDR_CTRL2, 8'h00);
    wr(`PGM_ADDR_MASK, 8'h04);
    tempWarnRaw <= 1'b1;
    cyc(3);
    bit1("masked irq", 1'b0, irqSeen);
    tempWarnRaw <= 1'b0;
    wr(`PGM_ADDR_INT, 8'h04);
    wr(`PGM_ADDR_MASK, 8'h00);
    st(8'h08);
    // Peak current qualification for each rail, rail 1 masked.
    peak <= 2'b01;
    cyc(1990);
    rd(`PGM_ADDR_INT, 8'h00, "peak early");
    cyc(20);
    rd(`PGM_ADDR_INT, 8'h01, "peak flag");
    rd(`PGM_ADDR_STATUS, 8'h09, "peak status");
    bit1("peak irq", 1'b1, irqSeen);
    wr(`PGM_ADDR_INT, 8'h01);
    rd(`PGM_ADDR_INT, 8'h01, "peak kept");
    peak <= 2'b00;
    cyc(1); // The qualified status lags the raw input by one edge.
    wr(`PGM_ADDR_INT, 8'h01);
    rd(`PGM_ADDR_INT, 8'h00, "peak clear");
    wr(`PGM_ADDR_MASK, 8'h02);
    peak <= 2'b10;
    cyc(2020);
    bit1("peak mask", 1'b0, irqSeen);
    peak <= 2'b00;
    // Undervoltage reset in mid-run clears a pending flag.
    inputOvRaw <= 1'b1;
    cyc(2);
    inputOvRaw <= 1'b0;
    rst6();
    rd(`PGM_ADDR_INT, 8'h00, "flags");
    // Continuous mode.
    otpBit <= 1'b1;
    cfgLoadDone <= 1'b1;
    railUnderOk <= 2'b00;
    st(8'h08);
    rd(`PGM_ADDR_CTRL2, 8'h02, "mode");
    railEnable <= 2'b01;
    st(8'h00);
    railUnderOk <= 2'b11;
    st(8'h08);
    rd(`PGM_ADDR_FAULT, 8'h01, "fault");
    railRamping <= 2'b01;
    st(8'h00);
    railRamping <= 2'b00;
    wr(`PGM_ADDR_CTRL2, 8'h06);
    st(8'h00);
    wr(`PGM_ADDR_FAULT, 8'h01);
    st(8'h08);
    wr(`PGM_ADDR_CTRL1, 8'h23);
    cyc(3);
    chk("pin", 8'h00, {6'h0, pgEnN, pinSeen});
    rd(`PGM_ADDR_STATUS, 8'h08, "status");
    wr(`PGM_ADDR_CTRL1, 8'h33);
    cyc(3);
    chk("pin", 8'h03, {6'h0, pgEnN, pinSeen});
    test_done();
  end
endmodule // power_good_and_warning_monitor_test
